// *** shared/sbc_pkg.sv ***
// Shared constants and types of the SPI register access layer
package sbc_pkg;
  // Frame layout: header in bits 15..12, data in bits 11..0
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int FSEL_BIT = 13;
  localparam int RO_BIT = 12;
  localparam int HDR_W = 4;
  // Mode register fields
  localparam int WDP_HI = 11;
  localparam int WDP_LO = 6;
  localparam int OM_HI = 5;
  localparam int OM_LO = 3;
  localparam int SDM_BIT = 2;
  localparam int EN_BIT = 1;
  localparam int RSS_W = 4;

  // Register addresses
  localparam logic [1:0] ADDR_MODE = 2'h0;
  localparam logic [1:0] ADDR_INT = 2'h1;
  localparam logic [1:0] ADDR_CFG = 2'h2;
  localparam logic [1:0] ADDR_PHY = 2'h3;

  // Operating mode codes
  localparam logic [2:0] OM_NONE = 3'h0;
  localparam logic [2:0] OM_NORMAL = 3'h1;
  localparam logic [2:0] OM_STANDBY = 3'h2;
  localparam logic [2:0] OM_INIT_FLASH = 3'h3;
  localparam logic [2:0] OM_SLEEP = 3'h4;
  localparam logic [2:0] OM_INIT_NORMAL = 3'h5;
  localparam logic [2:0] OM_LEAVE_FLASH = 3'h6;
  localparam logic [2:0] OM_FLASH = 3'h7;

  // Legal watchdog period codes
  localparam logic [5:0] WDP_C0 = 6'h09;
  localparam logic [5:0] WDP_C1 = 6'h0C;
  localparam logic [5:0] WDP_C2 = 6'h12;
  localparam logic [5:0] WDP_C3 = 6'h14;
  localparam logic [5:0] WDP_C4 = 6'h1B;
  localparam logic [5:0] WDP_C5 = 6'h24;
  localparam logic [5:0] WDP_C6 = 6'h2D;
  localparam logic [5:0] WDP_C7 = 6'h33;
  localparam logic [5:0] WDP_C8 = 6'h35;
  localparam logic [5:0] WDP_C9 = 6'h36;

  // Reset cause codes shown in the low nibble of the status word
  localparam logic [3:0] RSS_PIN = 4'h0;
  localparam logic [3:0] RSS_SPI_COUNT = 4'h1;
  localparam logic [3:0] RSS_ILLEGAL = 4'h2;
  localparam logic [3:0] RSS_FORBIDDEN = 4'h3;
  localparam logic [3:0] RSS_LEAVE_FLASH = 4'h4;
  localparam logic [3:0] RSS_FLASH_ENTRY = 4'hA;

  // Serial bit counter
  localparam logic [4:0] CNT_HEADER = 5'h04;
  localparam logic [4:0] CNT_FRAME = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1F;

  // Pin synchroniser idle levels: {reset pin, chip select, clock, data}
  localparam logic [3:0] PIN_IDLE = 4'hC;

  localparam logic [11:0] WORD_ZERO = 12'h000;

  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_RESTART,
    ST_NORMAL,
    ST_STANDBY,
    ST_FLASH,
    ST_SLEEP
  } sbc_op_state_t;
endpackage

// *** core/sbc_sync.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sbc_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sbc_sync_state_t;

  sbc_sync_state_t q, d;

  // First stage feeds only the second stage
  always_comb begin
    d.meta = async_i;
    d.stable = q.meta;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q <= '{meta: IDLE, stable: IDLE};
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.stable;
endmodule

// *** core/sbc_spi_frame.sv ***
// Serial frame engine: edge detection, bit counting, shift in and out
`timescale 1ns/10ps
module sbc_spi_frame (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic [11:0] tx_word_i,
  output logic [3:0] header_o,
  output logic header_ok_o,
  output logic [15:0] word_o,
  output logic done_o,
  output logic bad_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  typedef struct packed {
    logic sck_prev;
    logic cs_prev;
    logic active;
    logic [4:0] cnt;
    logic [15:0] shift;
    logic [10:0] tx;
    logic serial_out_pin;
    logic done;
    logic bad;
    logic [15:0] word;
  } sbc_frame_state_t;

  sbc_frame_state_t q, d;

  // Both clock edges are found from the sampled level, so delays match
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.bad = 1'b0;
    d.sck_prev = sck_i;
    d.cs_prev = cs_n_i;
    if (q.cs_prev && !cs_n_i) begin
      d.active = 1'b1;
      d.cnt = '0;
      d.serial_out_pin = 1'b0;
    end else if (!q.cs_prev && cs_n_i && q.active) begin
      d.active = 1'b0;
      d.done = (q.cnt == sbc_pkg::CNT_FRAME);
      d.bad = (q.cnt != sbc_pkg::CNT_FRAME);
      d.word = q.shift;
    end else if (q.active && !cs_n_i) begin
      if (q.sck_prev && !sck_i) begin
        // Sample on falling edge, MSB first
        d.shift = {q.shift[14:0], sdi_i};
        if (q.cnt != sbc_pkg::CNT_MAX) begin
          d.cnt = q.cnt + 5'h01; // Saturates so long frames never wrap to 16
        end
      end else if (!q.sck_prev && sck_i) begin
        // Shift on rising edge; header slots return zero
        if (q.cnt == sbc_pkg::CNT_HEADER) begin
          d.serial_out_pin = tx_word_i[11];
          d.tx = tx_word_i[10:0];
        end else if (q.cnt > sbc_pkg::CNT_HEADER) begin
          d.serial_out_pin = q.tx[10];
          d.tx = {q.tx[9:0], 1'b0};
        end else begin
          d.serial_out_pin = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q <= '{sck_prev: 1'b0, cs_prev: 1'b1, active: 1'b0, cnt: '0, shift: '0,
             tx: '0, serial_out_pin: 1'b0, done: 1'b0, bad: 1'b0, word: '0};
    end else begin
      q <= d;
    end
  end

  assign header_o = q.shift[3:0];
  assign header_ok_o = q.active && (q.cnt == sbc_pkg::CNT_HEADER);
  assign word_o = q.word;
  assign done_o = q.done;
  assign bad_o = q.bad;
  assign sdo_o = q.serial_out_pin;
  assign sdo_oe_o = q.active;
endmodule

// *** core/sbc_spi_regs.sv ***
// SPI register access layer with Mode register and flash entry tracking
`timescale 1ns/10ps
module sbc_spi_regs (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic spi_clock_i,
  input wire logic chip_select_pin_n_i,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  input wire logic system_reset_pin_n_i,
  input wire logic [11:0] system_status_i,
  input wire logic [11:0] system_diagnosis_i,
  input wire logic [11:0] interrupt_flags_i,
  output logic enable_o,
  output logic sw_debug_relax_o,
  output logic [5:0] watchdog_period_code_o,
  output logic [2:0] op_state_code_o,
  output sbc_pkg::sbc_op_state_t op_state_o,
  output logic [3:0] reset_cause_bits_o,
  output logic watchdog_service_o,
  output logic force_reset_o,
  output logic spi_failure_o,
  output logic interrupt_read_o,
  output logic [11:0] interrupt_enable_o,
  output logic [11:0] special_setup_o,
  output logic [11:0] system_configuration_o,
  output logic [11:0] physical_layer_control_o,
  output logic [11:0] general_purpose_0_o,
  output logic [11:0] general_purpose_1_o
);
  typedef struct packed {
    sbc_pkg::sbc_op_state_t state;
    logic [5:0] wdp;
    logic [2:0] om;
    logic sw_debug_relax;
    logic en;
    logic [11:0] int_en;
    logic [11:0] special;
    logic [11:0] syscfg;
    logic [11:0] phy;
    logic [11:0] gp0;
    logic [11:0] gp1;
    logic [1:0] seq;
    logic armed;
    logic [3:0] reset_cause_bits;
    logic svc;
    logic rst;
    logic fail;
    logic irq_rd;
  } sbc_regs_state_t;

  localparam sbc_regs_state_t POR = '{state: sbc_pkg::ST_STARTUP, wdp: '0, om: sbc_pkg::OM_NONE, sw_debug_relax: 1'b0,
    en: 1'b0, int_en: sbc_pkg::WORD_ZERO, special: sbc_pkg::WORD_ZERO, syscfg: sbc_pkg::WORD_ZERO,
    phy: sbc_pkg::WORD_ZERO, gp0: sbc_pkg::WORD_ZERO, gp1: sbc_pkg::WORD_ZERO, seq: '0, armed: 1'b0,
    reset_cause_bits: sbc_pkg::RSS_PIN, svc: 1'b0, rst: 1'b0, fail: 1'b0, irq_rd: 1'b0};

  sbc_regs_state_t q, d;
  logic [3:0] pins_s;
  logic [3:0] header;
  logic header_ok;
  logic [15:0] word;
  logic done;
  logic bad;
  logic [11:0] tx_word;

  // Start-up and Restart share the reduced register set
  function automatic logic is_boot(input sbc_pkg::sbc_op_state_t s);
    return (s == sbc_pkg::ST_STARTUP) || (s == sbc_pkg::ST_RESTART);
  endfunction

  // Normal and Standby reach the application registers
  function automatic logic is_run(input sbc_pkg::sbc_op_state_t s);
    return (s == sbc_pkg::ST_NORMAL) || (s == sbc_pkg::ST_STANDBY);
  endfunction

  function automatic logic wdp_legal(input logic [5:0] c);
    case (c)
      sbc_pkg::WDP_C0, sbc_pkg::WDP_C1, sbc_pkg::WDP_C2, sbc_pkg::WDP_C3, sbc_pkg::WDP_C4,
      sbc_pkg::WDP_C5, sbc_pkg::WDP_C6, sbc_pkg::WDP_C7, sbc_pkg::WDP_C8, sbc_pkg::WDP_C9: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // All pins cross into the clock domain before use
  sbc_sync #(
    .W(4),
    .IDLE(sbc_pkg::PIN_IDLE)
  ) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({system_reset_pin_n_i, chip_select_pin_n_i, spi_clock_i, serial_in_pin_i}),
    .sync_o(pins_s)
  );

  sbc_spi_frame u_frame (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .sck_i(pins_s[1]),
    .cs_n_i(pins_s[2]),
    .sdi_i(pins_s[0]),
    .tx_word_i(tx_word),
    .header_o(header),
    .header_ok_o(header_ok),
    .word_o(word),
    .done_o(done),
    .bad_o(bad),
    .sdo_o(serial_out_pin_o),
    .sdo_oe_o(serial_out_pin_oe_o)
  );

  // Feedback word picked from the header as soon as it is complete
  always_comb begin
    tx_word = sbc_pkg::WORD_ZERO;
    if (header_ok) begin
      case (header[3:2])
        sbc_pkg::ADDR_MODE: begin
          tx_word = header[1] ? system_diagnosis_i
                              : {system_status_i[11:4], q.reset_cause_bits};
        end
        sbc_pkg::ADDR_INT: begin
          if (!header[1]) begin
            tx_word = q.int_en;
          end else begin
            tx_word = is_boot(q.state) ? q.special : interrupt_flags_i;
          end
        end
        sbc_pkg::ADDR_CFG: begin
          tx_word = header[1] ? q.gp0 : q.syscfg;
        end
        sbc_pkg::ADDR_PHY: begin
          tx_word = header[1] ? q.gp1 : q.phy;
        end
        default: begin
          tx_word = sbc_pkg::WORD_ZERO;
        end
      endcase
    end
  end

  // Frame decode, Mode register checks and operating state tracking
  always_comb begin
    logic [1:0] addr;
    logic fsel;
    logic ro;
    logic [11:0] data;
    logic [5:0] wdp;
    logic [2:0] om;
    logic rst_req;
    logic [3:0] cause;
    addr = word[sbc_pkg::ADDR_HI:sbc_pkg::ADDR_LO];
    fsel = word[sbc_pkg::FSEL_BIT];
    ro = word[sbc_pkg::RO_BIT];
    data = word[sbc_pkg::DATA_BITS-1:0];
    wdp = data[sbc_pkg::WDP_HI:sbc_pkg::WDP_LO];
    om = data[sbc_pkg::OM_HI:sbc_pkg::OM_LO];
    rst_req = 1'b0;
    cause = sbc_pkg::RSS_PIN;
    d = q;
    d.svc = 1'b0;
    d.rst = 1'b0;
    d.fail = 1'b0;
    d.irq_rd = 1'b0;
    if (bad) begin
      // Miscounted frames are dropped whole
      if (is_boot(q.state)) begin
        rst_req = 1'b1;
        cause = sbc_pkg::RSS_SPI_COUNT;
      end else begin
        d.fail = 1'b1;
      end
    end else if (done) begin
      if ((addr == sbc_pkg::ADDR_INT) && fsel && !is_boot(q.state)) begin
        d.irq_rd = 1'b1; // Flags clear on read, even read only
      end
      if (!ro) begin
        case (addr)
          sbc_pkg::ADDR_MODE: begin
            // Accepted whatever the state; codes are checked first
            if (!wdp_legal(wdp) || (om == sbc_pkg::OM_NONE)) begin
              rst_req = 1'b1;
              cause = sbc_pkg::RSS_ILLEGAL;
            end else begin
              d.svc = 1'b1;
              d.wdp = wdp;
              d.om = om;
              d.sw_debug_relax = data[sbc_pkg::SDM_BIT];
              d.en = data[sbc_pkg::EN_BIT];
              case (q.state)
                sbc_pkg::ST_STARTUP, sbc_pkg::ST_RESTART: begin
                  d.armed = 1'b0;
                  d.seq = '0;
                  if (om == sbc_pkg::OM_INIT_NORMAL) begin
                    d.state = sbc_pkg::ST_NORMAL;
                  end else if ((om == sbc_pkg::OM_INIT_FLASH) && q.armed) begin
                    d.state = sbc_pkg::ST_FLASH;
                  end else begin
                    rst_req = 1'b1;
                    cause = sbc_pkg::RSS_FORBIDDEN;
                  end
                end
                sbc_pkg::ST_NORMAL: begin
                  case (om)
                    sbc_pkg::OM_NORMAL: begin
                      d.seq = (q.seq == 2'h2) ? 2'h3 : 2'h1;
                    end
                    sbc_pkg::OM_FLASH: begin
                      if (q.seq == 2'h1) begin
                        d.seq = 2'h2;
                      end else if (q.seq == 2'h3) begin
                        rst_req = 1'b1;
                        cause = sbc_pkg::RSS_FLASH_ENTRY;
                      end else begin
                        rst_req = 1'b1;
                        cause = sbc_pkg::RSS_FORBIDDEN;
                      end
                    end
                    sbc_pkg::OM_STANDBY: begin
                      d.state = sbc_pkg::ST_STANDBY;
                      d.seq = '0;
                    end
                    sbc_pkg::OM_SLEEP: begin
                      d.state = sbc_pkg::ST_SLEEP;
                      d.seq = '0;
                    end
                    default: begin
                      rst_req = 1'b1;
                      cause = sbc_pkg::RSS_FORBIDDEN;
                    end
                  endcase
                end
                sbc_pkg::ST_STANDBY: begin
                  case (om)
                    sbc_pkg::OM_NORMAL: begin
                      d.state = sbc_pkg::ST_NORMAL;
                      d.seq = 2'h1;
                    end
                    sbc_pkg::OM_STANDBY: begin
                      d.state = sbc_pkg::ST_STANDBY;
                    end
                    sbc_pkg::OM_SLEEP: begin
                      d.state = sbc_pkg::ST_SLEEP;
                    end
                    default: begin
                      rst_req = 1'b1;
                      cause = sbc_pkg::RSS_FORBIDDEN;
                    end
                  endcase
                end
                sbc_pkg::ST_FLASH: begin
                  if (om == sbc_pkg::OM_LEAVE_FLASH) begin
                    rst_req = 1'b1; // Leaving flash resets the controller into Start-up
                    cause = sbc_pkg::RSS_LEAVE_FLASH;
                  end else if (om != sbc_pkg::OM_FLASH) begin
                    rst_req = 1'b1;
                    cause = sbc_pkg::RSS_FORBIDDEN;
                  end
                end
                default: begin
                  rst_req = 1'b1;
                  cause = sbc_pkg::RSS_FORBIDDEN;
                end
              endcase
            end
          end
          sbc_pkg::ADDR_INT: begin
            if (is_boot(q.state)) begin
              d.special = data;
            end else if (q.state != sbc_pkg::ST_SLEEP) begin
              d.int_en = data;
            end
          end
          sbc_pkg::ADDR_CFG: begin
            if (is_run(q.state)) begin
              d.syscfg = data;
            end else if (q.state != sbc_pkg::ST_SLEEP) begin
              d.gp0 = data;
            end
          end
          sbc_pkg::ADDR_PHY: begin
            if (is_run(q.state)) begin
              d.phy = data;
            end else if (q.state != sbc_pkg::ST_SLEEP) begin
              d.gp1 = data;
            end
          end
          default: begin
            d.svc = 1'b0;
          end
        endcase
      end
    end
    // A forced reset discards the access and clears the Mode fields
    if (rst_req) begin
      d = POR;
      d.rst = 1'b1;
      d.reset_cause_bits = cause;
      d.armed = (cause == sbc_pkg::RSS_FLASH_ENTRY);
      d.state = ((cause == sbc_pkg::RSS_FLASH_ENTRY) || (cause == sbc_pkg::RSS_LEAVE_FLASH))
                ? sbc_pkg::ST_STARTUP : sbc_pkg::ST_RESTART;
    end
    // Low reset pin holds everything cleared except the reset cause bits; armed flash entry survives it
    if (!pins_s[3]) begin
      d = POR;
      d.reset_cause_bits = q.reset_cause_bits;
      d.armed = q.armed;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q <= POR;
    end else begin
      q <= d;
    end
  end

  assign enable_o = q.en;
  assign sw_debug_relax_o = q.sw_debug_relax;
  assign watchdog_period_code_o = q.wdp;
  assign op_state_code_o = q.om;
  assign op_state_o = q.state;
  assign reset_cause_bits_o = q.reset_cause_bits;
  assign watchdog_service_o = q.svc;
  assign force_reset_o = q.rst;
  assign spi_failure_o = q.fail;
  assign interrupt_read_o = q.irq_rd;
  assign interrupt_enable_o = q.int_en;
  assign special_setup_o = q.special;
  assign system_configuration_o = q.syscfg;
  assign physical_layer_control_o = q.phy;
  assign general_purpose_0_o = q.gp0;
  assign general_purpose_1_o = q.gp1;
endmodule

// *** test/sbc_spi_regs_properties.sv ***
// Port checks on the SPI register access layer
`timescale 1ns/10ps
module sbc_spi_regs_properties (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic chip_select_pin_n_i,
  input wire logic system_reset_pin_n_i,
  input wire logic serial_out_pin_oe_o,
  input wire logic enable_o,
  input wire sbc_pkg::sbc_op_state_t op_state_o,
  input wire logic watchdog_service_o,
  input wire logic force_reset_o,
  input wire logic spi_failure_o,
  input wire logic interrupt_read_o,
  input wire logic [11:0] special_setup_o,
  input wire logic [11:0] system_configuration_o
);
  logic [3:0] pin_q;
  logic fr_q;
  logic chg_ok;
  // Recent resets; the pin acts only after its synchroniser
  always_ff @(posedge clock_i) begin
    pin_q <= {pin_q[2:0], system_reset_pin_n_i};
    fr_q <= force_reset_o;
  end
  // Mode fields move only on a service or a reset
  assign chg_ok = watchdog_service_o || force_reset_o || fr_q || !(&pin_q);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  float_idle_a: assert property (chip_select_pin_n_i [*4] |-> !serial_out_pin_oe_o)
    else $error("output driven while idle");
  drive_sel_a: assert property ((!chip_select_pin_n_i && system_reset_pin_n_i) [*6]
    |-> serial_out_pin_oe_o)
    else $error("output not driven in frame");
  service_end_a: assert property (watchdog_service_o |-> $past(chip_select_pin_n_i, 3))
    else $error("service outside frame end");
  fail_mode_a: assert property (spi_failure_o |-> !force_reset_o
    && op_state_o != sbc_pkg::ST_STARTUP && op_state_o != sbc_pkg::ST_RESTART)
    else $error("count failure in wrong mode");
  en_change_a: assert property ($changed(enable_o) |-> chg_ok)
    else $error("enable moved alone");
  state_change_a: assert property ($changed(op_state_o) |-> chg_ok)
    else $error("state moved without service");
  setup_mode_a: assert property ($changed(special_setup_o)
    |-> op_state_o inside {sbc_pkg::ST_STARTUP, sbc_pkg::ST_RESTART})
    else $error("setup written in wrong mode");
  cfg_mode_a: assert property ($changed(system_configuration_o)
    |-> system_configuration_o == 12'h000
    || $past(op_state_o) inside {sbc_pkg::ST_NORMAL, sbc_pkg::ST_STANDBY})
    else $error("config written in wrong mode");
  irq_read_a: assert property (interrupt_read_o |-> $past(chip_select_pin_n_i, 3)
    && op_state_o != sbc_pkg::ST_STARTUP && op_state_o != sbc_pkg::ST_RESTART)
    else $error("flag read in wrong mode");
endmodule
bind sbc_spi_regs sbc_spi_regs_properties chk (.clock_i, .sys_rst_i, .chip_select_pin_n_i,
  .system_reset_pin_n_i, .serial_out_pin_oe_o, .enable_o, .op_state_o, .watchdog_service_o,
  .force_reset_o, .spi_failure_o, .interrupt_read_o, .special_setup_o, .system_configuration_o);

// *** test/sbc_host_model.sv ***
// Host SPI master model for the serial link
`timescale 1ns/10ps
module sbc_host_model (
  input wire logic clock_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic sdi_o
);
  // Idle pins; clock rests low
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Pins change just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // Frame of n periods; 16 is legal, other counts test refusal
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    tick(1);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      tick(4);
      sck_o = 1'b1;
      sdi_o = (i < 16) ? w[15 - i] : ~sdi_o; // Shift on rising, bit 15 first
      tick(4);
      sck_o = 1'b0;
      r = {r[14:0], sdo_i}; // Sample on falling
    end
    tick(4);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // Released line must not look held
    tick(4);
  endtask
endmodule

// *** test/test_sbc_spi_regs.sv ***
// Self-checking bench for the SPI register access layer
`timescale 1ns/10ps
module test_sbc_spi_regs;
  typedef struct packed {
    logic [15:0] w;
    logic [11:0] fb;
    sbc_pkg::sbc_op_state_t st;
  } sbc_row_t;
  localparam sbc_pkg::sbc_op_state_t SU = sbc_pkg::ST_STARTUP;
  localparam sbc_pkg::sbc_op_state_t RS = sbc_pkg::ST_RESTART;
  localparam sbc_pkg::sbc_op_state_t NM = sbc_pkg::ST_NORMAL;
  localparam sbc_pkg::sbc_op_state_t SB = sbc_pkg::ST_STANDBY;
  localparam sbc_pkg::sbc_op_state_t FL = sbc_pkg::ST_FLASH;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic system_reset_pin_n_i = 1'b1;
  logic spi_clock_i, chip_select_pin_n_i, serial_in_pin_i, serial_out_pin_o, serial_out_pin_oe_o;
  logic enable_o, sw_debug_relax_o, watchdog_service_o, force_reset_o, spi_failure_o, interrupt_read_o;
  logic [11:0] system_status_i = 12'hA50;
  logic [11:0] system_diagnosis_i = 12'h3C3;
  logic [11:0] interrupt_flags_i = 12'h5A5;
  logic [11:0] interrupt_enable_o, special_setup_o, system_configuration_o;
  logic [11:0] physical_layer_control_o, general_purpose_0_o, general_purpose_1_o;
  logic [5:0] watchdog_period_code_o;
  logic [2:0] op_state_code_o;
  logic [3:0] reset_cause_bits_o;
  sbc_pkg::sbc_op_state_t op_state_o;
  wire sdo_w = serial_out_pin_oe_o ? serial_out_pin_o : 1'bz;
  int n_fail = 0;
  int cmp_count = 0;
  int n_sf = 0;
  int n_fr = 0;
  int n_ir = 0;
  int n_ws = 0;
  // Frame word, feedback expected, state after; mode words keep bit 0 clear
  sbc_row_t rows [30] = '{
    '{16'h4123, 12'h000, SU}, '{16'h7FFF, 12'h123, SU}, '{16'h7000, 12'h123, SU},
    '{16'hA0F0, 12'h000, SU}, '{16'hE00F, 12'h000, SU}, '{16'hB000, 12'h0F0, SU},
    '{16'hF000, 12'h00F, SU}, '{16'h026A, 12'hA50, NM}, '{16'h3000, 12'h3C3, NM},
    '{16'h40AB, 12'h000, NM}, '{16'h5000, 12'h0AB, NM}, '{16'h7000, 12'h5A5, NM},
    '{16'h8321, 12'h000, NM}, '{16'h9000, 12'h321, NM}, '{16'hB000, 12'h0F0, NM},
    '{16'hC456, 12'h000, NM}, '{16'hD000, 12'h456, NM}, '{16'h0252, 12'hA50, SB},
    '{16'h024A, 12'hA50, NM}, '{16'h027A, 12'hA50, NM}, '{16'h024A, 12'hA50, NM},
    '{16'h027A, 12'hA50, SU}, '{16'h1000, 12'hA5A, SU}, '{16'h025A, 12'hA5A, FL},
    '{16'hA777, 12'h000, FL}, '{16'hB000, 12'h777, FL}, '{16'h0272, 12'hA5A, SU},
    '{16'h026A, 12'hA54, NM}, '{16'h000A, 12'hA54, RS}, '{16'h024A, 12'hA52, RS}};
  sbc_host_model host (.clock_i, .sdo_i(sdo_w), .sck_o(spi_clock_i), .cs_n_o(chip_select_pin_n_i),
    .sdi_o(serial_in_pin_i));
  sbc_spi_regs dut (.clock_i, .sys_rst_i, .spi_clock_i, .chip_select_pin_n_i, .serial_in_pin_i,
    .serial_out_pin_o, .serial_out_pin_oe_o, .system_reset_pin_n_i, .system_status_i,
    .system_diagnosis_i, .interrupt_flags_i, .enable_o, .sw_debug_relax_o, .watchdog_period_code_o,
    .op_state_code_o, .op_state_o, .reset_cause_bits_o, .watchdog_service_o, .force_reset_o,
    .spi_failure_o, .interrupt_read_o, .interrupt_enable_o, .special_setup_o, .system_configuration_o,
    .physical_layer_control_o, .general_purpose_0_o, .general_purpose_1_o);
  // 20 MHz system clock
  always #25 clock_i = ~clock_i;
  // Pulse tallies, read one cycle late so no race
  always @(posedge clock_i) begin
    if (spi_failure_o === 1'b1) n_sf++;
    if (force_reset_o === 1'b1) n_fr++;
    if (interrupt_read_o === 1'b1) n_ir++;
    if (watchdog_service_o === 1'b1) n_ws++;
  end
  task automatic end_of_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Full frame, then wait out the four cycle effect latency
  task automatic frame(input sbc_row_t row);
    logic [15:0] r;
    host.xfer(row.w, 16, r);
    repeat (8) @(posedge clock_i);
    check(r, {4'h0, row.fb});
    check(op_state_o, row.st);
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clock_i);
    n_fail++;
    end_of_test();
  end
  initial begin
    logic [15:0] r;
    repeat (12) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    check({op_state_o, enable_o, serial_out_pin_oe_o, reset_cause_bits_o}, {SU, 6'h00});
    repeat (3) @(posedge clock_i);
    foreach (rows[i]) frame(rows[i]);
    check(n_fr, 4);
    host.xfer(16'h4000, 15, r);
    repeat (8) @(posedge clock_i);
    check({n_fr[3:0], op_state_o, reset_cause_bits_o}, {4'h5, RS, sbc_pkg::RSS_SPI_COUNT});
    frame('{16'h026A, 12'hA51, NM});
    frame('{16'h024C, 12'hA51, NM});
    check({sw_debug_relax_o, enable_o, watchdog_period_code_o, op_state_code_o},
      {2'b10, 6'h09, 3'h1});
    frame('{16'h8321, 12'h000, NM});
    frame('{16'hC456, 12'h000, NM});
    check(system_configuration_o, 12'h321);
    check(physical_layer_control_o, 12'h456);
    // Sleep takes the Mode write but refuses register writes
    frame('{16'h0266, 12'hA51, sbc_pkg::ST_SLEEP});
    frame('{16'h40AB, 12'h000, sbc_pkg::ST_SLEEP});
    host.xfer(16'h4FFF, 17, r);
    repeat (8) @(posedge clock_i);
    check({n_sf[3:0], interrupt_enable_o}, 16'h1000);
    #1;
    system_reset_pin_n_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    system_reset_pin_n_i = 1'b1;
    repeat (6) @(posedge clock_i);
    check({op_state_o, sw_debug_relax_o, reset_cause_bits_o}, {SU, 1'b0, 4'h1});
    check(n_ir, 1);
    // Boot mode reaches the setup and general purpose words
    frame('{16'h4123, 12'h000, SU});
    frame('{16'hA0F0, 12'h000, SU});
    frame('{16'hE00F, 12'h000, SU});
    check(special_setup_o, 12'h123);
    check(general_purpose_0_o, 12'h0F0);
    check(general_purpose_1_o, 12'h00F);
    // Host serves the Mode register once the reset pin is back high
    frame('{16'h026A, 12'hA51, NM});
    check(n_ws, 11);
    end_of_test();
  end
endmodule
